/* uibg_pkg.sv */
// constants shared by the uart interrupt-enable, baud generator and scratch block
package uibg_pkg;
  // ==========================================================================
  // register byte offsets (apb word aligned)
  localparam logic [7:0] OFF_IRQ_EN = 8'h00;
  localparam logic [7:0] OFF_DIV_LO = 8'h04;
  localparam logic [7:0] OFF_DIV_HI = 8'h08;
  localparam logic [7:0] OFF_SCRATCH = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ID = 8'h10;
  localparam logic [7:0] OFF_LINE_ST = 8'h14;
  localparam logic [7:0] OFF_MODEM_ST = 8'h18;
  localparam logic [7:0] OFF_MODEM_CTL = 8'h1c;
  localparam logic [7:0] OFF_SPEED = 8'h20;
  localparam logic [7:0] OFF_PRESCALE = 8'h24;
  localparam logic [7:0] OFF_EV_STAT = 8'h28;
  localparam logic [7:0] OFF_EV_MASK = 8'h2c;
  // ==========================================================================
  // field positions
  localparam int IEN_RX = 0;
  localparam int IEN_TX = 1;
  localparam int IEN_LINE = 2;
  localparam int IEN_MODEM = 3;
  localparam logic [7:0] IEN_WMASK = 8'h0f;
  localparam int MCTL_IRQ_OUT = 3;
  localparam int SPD_HS_LSB = 6;
  localparam logic [1:0] SPD_HS_SEL = 2'h3;
  localparam logic [1:0] PRE_SEL_13 = 2'h0;
  localparam logic [1:0] PRE_SEL_1625 = 2'h1;
  localparam logic [1:0] PRE_SEL_1 = 2'h2;
  localparam int EV_LINE = 0;
  localparam int EV_MODEM = 1;
  localparam int EV_RX = 2;
  localparam int EV_TX = 3;
  localparam int EV_W = 4;
  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_DIV_LO = 8'h01;
  localparam logic [7:0] RST_DIV_HI = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ==========================================================================
  // pre-divider: modulus 13, step per 24 mhz edge gives /13, /1.625, /1.0
  localparam logic [3:0] PRE_MOD = 4'hd;
  localparam logic [3:0] PRE_STEP_13 = 4'h1;
  localparam logic [3:0] PRE_STEP_1625 = 4'h8;
  localparam logic [3:0] PRE_STEP_1 = 4'hd;
  // ==========================================================================
  // interrupt identity codes, bit 0 high means nothing pending
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RX = 4'h4;
  localparam logic [3:0] ID_TMO = 4'hc;
  localparam logic [3:0] ID_TX = 4'h2;
  localparam logic [3:0] ID_MODEM = 4'h0;
endpackage

/* uibg_baud.sv */
// pre-divider and 16-bit divisor counter producing the 16x bit tick
`timescale 1ns/1ps
module uibg_baud #(
  parameter int DIV_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ref_tick,
  input wire logic [3:0] pre_step,
  input wire logic [DIV_W-1:0] divisor,
  output logic pre_tick_r,
  output logic baud16_tick_r
);
  // ==========================================================================
  // checks
  if (DIV_W < 2 || DIV_W > 16)
    $error("uibg_baud: DIV_W must be 2..16");

  logic [4:0] acc_r; // fractional pre-divider accumulator
  logic [4:0] acc_sum; // accumulator plus step
  logic [DIV_W-1:0] cnt_r; // divisor down counter
  logic [DIV_W-1:0] div_act_r; // divisor latched at reload

  assign acc_sum = acc_r + {1'b0, pre_step};

  // ==========================================================================
  // fractional pre-divider: one tick each time the sum reaches or passes the modulus
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_r <= 5'h00;
      pre_tick_r <= 1'b0;
    end
    else if (ref_tick)
    begin
      // sum stays below 26, one subtraction is enough
      if (acc_sum >= {1'b0, uibg_pkg::PRE_MOD})
      begin
        acc_r <= acc_sum - {1'b0, uibg_pkg::PRE_MOD};
        pre_tick_r <= 1'b1;
      end
      else
      begin
        acc_r <= acc_sum;
        pre_tick_r <= 1'b0;
      end
    end
    else
      pre_tick_r <= 1'b0;
  end

  // ==========================================================================
  // divisor counter; a new divisor is picked up only at reload
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      div_act_r <= '0;
      baud16_tick_r <= 1'b0;
    end
    else if (pre_tick_r && cnt_r <= DIV_W'(1))
    begin
      // zero divisor stops the generator rather than dividing by 65536
      cnt_r <= divisor;
      div_act_r <= divisor;
      baud16_tick_r <= (div_act_r != '0);
    end
    else
    begin
      if (pre_tick_r)
        cnt_r <= cnt_r - DIV_W'(1);
      baud16_tick_r <= 1'b0;
    end
  end

  AST_TICK_NEEDS_PRE: assert property (@(posedge mclk) disable iff (rst)
    baud16_tick_r |-> $past(pre_tick_r))
    else $error("baud tick without a pre-divider tick");
  AST_DIV1_EVERY_PRE: assert property (@(posedge mclk) disable iff (rst)
    (pre_tick_r && div_act_r == DIV_W'(1) && divisor == DIV_W'(1)) |=> baud16_tick_r)
    else $error("divisor one must tick on every pre tick");
  AST_PRE_BY_ONE: assert property (@(posedge mclk) disable iff (rst)
    (ref_tick && pre_step == uibg_pkg::PRE_STEP_1) |=> pre_tick_r)
    else $error("pre-divider 1.0 missed an input edge");
  COV_BAUD_TICK: cover property (@(posedge mclk) disable iff (rst) baud16_tick_r);
endmodule

/* uibg_irq.sv */
// per-source enable gating and priority encoding of the uart interrupt
`timescale 1ns/1ps
module uibg_irq (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] src_en,
  input wire logic master_en,
  input wire logic line_pend,
  input wire logic rx_pend,
  input wire logic rx_tmo_pend,
  input wire logic tx_pend,
  input wire logic modem_pend,
  output logic [3:0] irq_id_r,
  output logic uart_irq_r
);
  logic [3:0] id_nxt; // identity of the top enabled source
  logic line_g; // gated sources
  logic rx_g;
  logic tmo_g;
  logic tx_g;
  logic modem_g;

  assign line_g = line_pend & src_en[uibg_pkg::IEN_LINE];
  assign rx_g = rx_pend & src_en[uibg_pkg::IEN_RX];
  assign tmo_g = rx_tmo_pend & src_en[uibg_pkg::IEN_RX];
  assign tx_g = tx_pend & src_en[uibg_pkg::IEN_TX];
  assign modem_g = modem_pend & src_en[uibg_pkg::IEN_MODEM];

  // ==========================================================================
  // fixed priority: line, data ready or timeout, tx empty, modem
  always_comb
  begin
    if (line_g)
      id_nxt = uibg_pkg::ID_LINE;
    else if (tmo_g)
      id_nxt = uibg_pkg::ID_TMO;
    else if (rx_g)
      id_nxt = uibg_pkg::ID_RX;
    else if (tx_g)
      id_nxt = uibg_pkg::ID_TX;
    else if (modem_g)
      id_nxt = uibg_pkg::ID_MODEM;
    else
      id_nxt = uibg_pkg::ID_NONE;
  end

  // ==========================================================================
  // registered identity and output; the master enable gates only the pin
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_id_r <= uibg_pkg::ID_NONE;
      uart_irq_r <= 1'b0;
    end
    else
    begin
      irq_id_r <= id_nxt;
      uart_irq_r <= master_en & ~id_nxt[0];
    end
  end

  AST_NO_EN_NO_IRQ: assert property (@(posedge mclk) disable iff (rst)
    ($past(src_en) == 4'h0) |-> !uart_irq_r)
    else $error("interrupt raised with all sources disabled");
  AST_MASTER_GATES: assert property (@(posedge mclk) disable iff (rst)
    !$past(master_en) |-> !uart_irq_r)
    else $error("interrupt raised with output enable off");
  AST_LINE_FIRST: assert property (@(posedge mclk) disable iff (rst)
    $past(line_g) |-> irq_id_r == uibg_pkg::ID_LINE)
    else $error("line status not reported first");
  AST_MODEM_LAST: assert property (@(posedge mclk) disable iff (rst)
    ($past(modem_g) && !$past(line_g | rx_g | tmo_g | tx_g) && $past(master_en))
    |-> (uart_irq_r && irq_id_r == uibg_pkg::ID_MODEM))
    else $error("modem change did not raise the interrupt");
  AST_TX_GATED: assert property (@(posedge mclk) disable iff (rst)
    ($past(tx_pend) && !$past(src_en[uibg_pkg::IEN_TX]))
    |-> irq_id_r != uibg_pkg::ID_TX)
    else $error("masked tx empty reported");
  COV_IRQ_RAISED: cover property (@(posedge mclk) disable iff (rst) $rose(uart_irq_r));
  COV_LINE_OVER_RX: cover property (@(posedge mclk) disable iff (rst) line_g && rx_g);
endmodule

/* uibg_top.sv */
// uart interrupt enable, baud generator and scratch register with apb access
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module uibg_top #(
  parameter int DIV_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // 24 mhz reference pin
  input wire logic ref_clk_24m,
  // conditions from the receiver, transmitter and handshake logic
  input wire logic rx_ready,
  input wire logic rx_timeout,
  input wire logic tx_empty,
  input wire logic [3:0] line_err_set,
  input wire logic [3:0] modem_delta_set,
  input wire logic [3:0] modem_level,
  // outputs to the transmitter, receiver and system
  output logic baud16_tick,
  output logic [7:0] modem_ctl_out,
  output logic irq_id_read,
  output logic uart_irq,
  output logic sys_irq
);
  // ==========================================================================
  // checks
  if (DIV_W != 16)
    $error("uibg_top: divisor is two 8-bit registers, DIV_W must be 16");

  // ==========================================================================
  // declarations
  logic [3:0] irq_en_r; // low nibble of interrupt_enable
  logic [7:0] div_lo_r; // divisor_low
  logic [7:0] div_hi_r; // divisor_high
  logic [7:0] scratch_r; // scratch, no side effects
  logic [7:0] modem_ctl_r; // modem_control
  logic [7:0] speed_r; // speed_config
  logic [7:0] prescale_r; // prescale_config
  logic [3:0] line_st_r; // sticky line error flags
  logic [3:0] modem_st_r; // sticky modem change flags
  logic [3:0] ev_stat_r; // sticky event status, write one to clear
  logic [3:0] ev_mask_r; // event mask, one lets the event through
  logic [31:0] rdata_r; // read data caught in the setup cycle
  logic hit_r; // address decoded in the setup cycle
  logic [3:0] line_snap_r; // line flags that the pending read returns
  logic [3:0] modem_snap_r; // modem flags that the pending read returns
  logic [31:0] rdata_nxt; // read mux
  logic hit_nxt; // address decode
  logic setup; // apb setup cycle
  logic acc_wr; // completing write
  logic acc_rd; // completing read
  logic ref_s1_r; // reference pin synchroniser, first stage
  logic ref_s2_r; // second stage
  logic ref_s3_r; // edge detect history
  logic ref_tick; // one pulse per reference rising edge
  logic high_speed; // speed_config selects raw 24 mhz
  logic [3:0] pre_step; // accumulator step for the pre-divider
  logic pre_tick; // pre-divider tick, watched by the high speed check
  logic [3:0] irq_id; // current identity code
  logic rx_ready_d_r; // delayed levels for rise detection
  logic tx_empty_d_r;
  logic [3:0] ev_set; // event pulses into the sticky status
  logic [3:0] ev_wclr; // software clear of event bits

  // ==========================================================================
  // apb handshake: zero wait, data registered during setup
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign acc_wr = psel & penable & pwrite & hit_r;
  assign acc_rd = psel & penable & ~pwrite & hit_r;
  assign pslverr = psel & penable & ~hit_r;
  assign prdata = rdata_r;
  // the tx logic clears a third-priority tx empty on this pulse
  assign irq_id_read = acc_rd && (paddr == uibg_pkg::OFF_IRQ_ID);

  // ==========================================================================
  // read mux and address decode
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (paddr)
      uibg_pkg::OFF_IRQ_EN: rdata_nxt = {28'h000_0000, irq_en_r};
      uibg_pkg::OFF_DIV_LO: rdata_nxt = {24'h00_0000, div_lo_r};
      uibg_pkg::OFF_DIV_HI: rdata_nxt = {24'h00_0000, div_hi_r};
      uibg_pkg::OFF_SCRATCH: rdata_nxt = {24'h00_0000, scratch_r};
      uibg_pkg::OFF_IRQ_ID: rdata_nxt = {28'h000_0000, irq_id};
      uibg_pkg::OFF_LINE_ST: rdata_nxt = {24'h00_0000, line_st_r, 4'h0};
      uibg_pkg::OFF_MODEM_ST: rdata_nxt = {24'h00_0000, modem_level, modem_st_r};
      uibg_pkg::OFF_MODEM_CTL: rdata_nxt = {24'h00_0000, modem_ctl_r};
      uibg_pkg::OFF_SPEED: rdata_nxt = {24'h00_0000, speed_r};
      uibg_pkg::OFF_PRESCALE: rdata_nxt = {24'h00_0000, prescale_r};
      uibg_pkg::OFF_EV_STAT: rdata_nxt = {28'h000_0000, ev_stat_r};
      uibg_pkg::OFF_EV_MASK: rdata_nxt = {28'h000_0000, ev_mask_r};
      default:
        hit_nxt = 1'b0; // unmapped: zero data and an error response
    endcase
  end

  // ==========================================================================
  // setup-cycle capture of read data and of the flags it reports
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_r <= 32'h0000_0000;
      hit_r <= 1'b0;
      line_snap_r <= 4'h0;
      modem_snap_r <= 4'h0;
    end
    else if (setup)
    begin
      rdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
      hit_r <= hit_nxt;
      line_snap_r <= line_st_r;
      modem_snap_r <= modem_st_r;
    end
  end

  // ==========================================================================
  // interrupt_enable: only the low nibble is stored
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_en_r <= uibg_pkg::RST_IRQ_EN[3:0];
    else if (acc_wr && paddr == uibg_pkg::OFF_IRQ_EN)
      irq_en_r <= pwdata[3:0] & uibg_pkg::IEN_WMASK[3:0];
  end

  // ==========================================================================
  // divisor bytes; the generator samples them only at reload
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_lo_r <= uibg_pkg::RST_DIV_LO;
      div_hi_r <= uibg_pkg::RST_DIV_HI;
    end
    else if (acc_wr)
    begin
      if (paddr == uibg_pkg::OFF_DIV_LO)
        div_lo_r <= pwdata[7:0];
      if (paddr == uibg_pkg::OFF_DIV_HI)
        div_hi_r <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // scratch and configuration bytes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scratch_r <= uibg_pkg::RST_BYTE;
      modem_ctl_r <= uibg_pkg::RST_BYTE;
      speed_r <= uibg_pkg::RST_BYTE;
      prescale_r <= uibg_pkg::RST_BYTE;
    end
    else if (acc_wr)
    begin
      case (paddr)
        uibg_pkg::OFF_SCRATCH: scratch_r <= pwdata[7:0];
        uibg_pkg::OFF_MODEM_CTL: modem_ctl_r <= pwdata[7:0];
        uibg_pkg::OFF_SPEED: speed_r <= pwdata[7:0];
        uibg_pkg::OFF_PRESCALE: prescale_r <= pwdata[7:0];
        default:
          scratch_r <= scratch_r; // other offsets leave these alone
      endcase
    end
  end

  assign modem_ctl_out = modem_ctl_r;

  // ==========================================================================
  // line status: sticky errors, cleared by reading; a new error wins
  always_ff @(posedge mclk)
  begin
    if (rst)
      line_st_r <= 4'h0;
    else if (acc_rd && paddr == uibg_pkg::OFF_LINE_ST)
      line_st_r <= (line_st_r & ~line_snap_r) | line_err_set;
    else
      line_st_r <= line_st_r | line_err_set;
  end

  // ==========================================================================
  // modem change flags, cleared by reading modem_status
  always_ff @(posedge mclk)
  begin
    if (rst)
      modem_st_r <= 4'h0;
    else if (acc_rd && paddr == uibg_pkg::OFF_MODEM_ST)
      modem_st_r <= (modem_st_r & ~modem_snap_r) | modem_delta_set;
    else
      modem_st_r <= modem_st_r | modem_delta_set;
  end

  // ==========================================================================
  // reference pin: two flops, then an edge detector on the second
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end
    else
    begin
      ref_s1_r <= ref_clk_24m;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  assign ref_tick = ref_s2_r & ~ref_s3_r;

  // ==========================================================================
  // pre-divider select; high speed overrides the prescale register
  assign high_speed = (speed_r[uibg_pkg::SPD_HS_LSB +: 2] == uibg_pkg::SPD_HS_SEL);

  always_comb
  begin
    if (high_speed)
      pre_step = uibg_pkg::PRE_STEP_1;
    else
    begin
      case (prescale_r[1:0])
        uibg_pkg::PRE_SEL_1625: pre_step = uibg_pkg::PRE_STEP_1625;
        uibg_pkg::PRE_SEL_1: pre_step = uibg_pkg::PRE_STEP_1;
        default: pre_step = uibg_pkg::PRE_STEP_13;
      endcase
    end
  end

  // ==========================================================================
  // baud generator
  uibg_baud #(
    .DIV_W(DIV_W)
  ) u_baud (
    .mclk(mclk),
    .rst(rst),
    .ref_tick(ref_tick),
    .pre_step(pre_step),
    .divisor({div_hi_r, div_lo_r}),
    .pre_tick_r(pre_tick),
    .baud16_tick_r(baud16_tick)
  );

  // ==========================================================================
  // interrupt gating and identity
  uibg_irq u_irq (
    .mclk(mclk),
    .rst(rst),
    .src_en(irq_en_r),
    .master_en(modem_ctl_r[uibg_pkg::MCTL_IRQ_OUT]),
    .line_pend(|line_st_r),
    .rx_pend(rx_ready),
    .rx_tmo_pend(rx_timeout),
    .tx_pend(tx_empty),
    .modem_pend(|modem_st_r),
    .irq_id_r(irq_id),
    .uart_irq_r(uart_irq)
  );

  // ==========================================================================
  // system event status: set on rising conditions, write one to clear
  assign ev_set[uibg_pkg::EV_LINE] = |line_err_set;
  assign ev_set[uibg_pkg::EV_MODEM] = |modem_delta_set;
  assign ev_set[uibg_pkg::EV_RX] = rx_ready & ~rx_ready_d_r;
  assign ev_set[uibg_pkg::EV_TX] = tx_empty & ~tx_empty_d_r;
  assign ev_wclr = (acc_wr && paddr == uibg_pkg::OFF_EV_STAT) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_ready_d_r <= 1'b0;
      tx_empty_d_r <= 1'b0;
      ev_stat_r <= 4'h0;
      ev_mask_r <= 4'h0;
      sys_irq <= 1'b0;
    end
    else
    begin
      rx_ready_d_r <= rx_ready;
      tx_empty_d_r <= tx_empty;
      // set wins over a clear in the same cycle
      ev_stat_r <= (ev_stat_r & ~ev_wclr) | ev_set;
      if (acc_wr && paddr == uibg_pkg::OFF_EV_MASK)
        ev_mask_r <= pwdata[3:0];
      sys_irq <= |(ev_stat_r & ev_mask_r);
    end
  end

  // ==========================================================================
  // checks on the register file
  AST_IEN_UPPER_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (acc_rd && paddr == uibg_pkg::OFF_IRQ_EN) |-> prdata[7:4] == 4'h0)
    else $error("upper enable bits read non-zero");
  AST_SCRATCH_BACK: assert property (@(posedge mclk) disable iff (rst)
    (acc_wr && paddr == uibg_pkg::OFF_SCRATCH) ##1 (!acc_wr [*2])
    |-> scratch_r == $past(pwdata[7:0], 3))
    else $error("scratch did not hold the written byte");
  AST_LINE_CLEAR: assert property (@(posedge mclk) disable iff (rst)
    (acc_rd && paddr == uibg_pkg::OFF_LINE_ST && line_err_set == 4'h0)
    |=> (line_st_r & $past(line_snap_r)) == 4'h0)
    else $error("line status read did not clear errors");
  AST_LINE_SET_WINS: assert property (@(posedge mclk) disable iff (rst)
    (line_err_set != 4'h0) |=> (line_st_r & $past(line_err_set)) == $past(line_err_set))
    else $error("line error lost");
  AST_DIV_LOW_BYTE: assert property (@(posedge mclk) disable iff (rst)
    (acc_wr && paddr == uibg_pkg::OFF_DIV_LO) |=> div_lo_r == $past(pwdata[7:0]))
    else $error("divisor low byte not written");
  AST_HS_STEP: assert property (@(posedge mclk) disable iff (rst)
    (high_speed && ref_tick) |=> pre_tick)
    else $error("high speed missed a reference edge");
  COV_LINE_READ: cover property (@(posedge mclk) disable iff (rst)
    acc_rd && paddr == uibg_pkg::OFF_LINE_ST && line_st_r != 4'h0);
  COV_SYS_IRQ: cover property (@(posedge mclk) disable iff (rst) $rose(sys_irq));
endmodule

/* uibg_far.sv */
// far-side model: the 24 mhz reference pin of the baud generator
`timescale 1ns/1ps
module uibg_far (
  output logic ref_clk_24m
);
  // ==========================================================
  // free-running reference, phase unrelated to mclk on purpose
  initial
  begin
    ref_clk_24m = 1'b0;
    #7.3;
    forever #20.833 ref_clk_24m = ~ref_clk_24m;
  end
endmodule

/* uart_irq_enable_baud_gen_tb.sv */
// self-checking testbench of the uart interrupt-enable, baud and scratch block
`timescale 1ns/1ps
module uart_irq_enable_baud_gen_tb;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, ref_clk_24m, tick, uart_irq, sys_irq, id_rd, ir;
  logic rx_ready = 1'b0, rx_timeout = 1'b0, tx_empty = 1'b0;
  logic [3:0] line_err_set = 4'h0, modem_delta_set = 4'h0;
  logic [7:0] modem_ctl_out;
  int checks = 0, fail_count = 0, cyc = 0, ticks = 0;
  logic [3:0] ids [4] = '{uibg_pkg::ID_RX, uibg_pkg::ID_TX, uibg_pkg::ID_LINE,
    uibg_pkg::ID_MODEM};
  int pre8 [4] = '{104, 13, 8, 8}; // pre-divider in eighths; high speed forces 1.0
  logic [7:0] pre_sel [4] = '{8'h0, 8'h1, 8'h2, 8'h0};
  logic [7:0] spd [4] = '{8'h00, 8'h00, 8'h00, 8'hc0};
  // ==========================================================
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  uibg_far far_u (.ref_clk_24m(ref_clk_24m));
  uibg_top dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_24m(ref_clk_24m),
    .rx_ready(rx_ready), .rx_timeout(rx_timeout), .tx_empty(tx_empty),
    .line_err_set(line_err_set), .modem_delta_set(modem_delta_set),
    .modem_level(4'ha), .baud16_tick(tick), .modem_ctl_out(modem_ctl_out),
    .irq_id_read(id_rd), .uart_irq(uart_irq), .sys_irq(sys_irq));
  // tick counter and hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (tick === 1'b1)
      ticks++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // ==========================================================
  task end_of_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    ir = id_rd;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic rid(input logic [3:0] c);
    repeat (4) @(posedge mclk);
    rd(uibg_pkg::OFF_IRQ_ID, {28'h0, c});
    chk(ir, 1'b1);
  endtask
  // raise source i: 0 rx, 1 tx, 2 line error, 3 modem change
  task automatic src(input int i);
    case (i)
      0: rx_ready <= 1'b1;
      1: tx_empty <= 1'b1;
      2: line_err_set <= 4'h1;
      default: modem_delta_set <= 4'h1;
    endcase
    @(posedge mclk);
    line_err_set <= 4'h0;
    modem_delta_set <= 4'h0;
    repeat (4) @(posedge mclk);
  endtask
  // ==========================================================
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(uibg_pkg::OFF_DIV_LO, 32'h1);
    chk(ir, 1'b0);
    rd(uibg_pkg::OFF_SCRATCH, 32'h0);
    apb(1'b1, uibg_pkg::OFF_IRQ_EN, 32'hff);
    rd(uibg_pkg::OFF_IRQ_EN, 32'hf);
    apb(1'b1, uibg_pkg::OFF_SCRATCH, 32'ha5);
    rd(uibg_pkg::OFF_SCRATCH, 32'ha5);
    apb(1'b1, uibg_pkg::OFF_DIV_HI, 32'h1);
    rd(uibg_pkg::OFF_DIV_HI, 32'h1);
    // back to 1 before the first reload, else a 257 period swallows the baud test
    apb(1'b1, uibg_pkg::OFF_DIV_HI, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, uibg_pkg::OFF_MODEM_CTL, 32'h8);
    chk(modem_ctl_out, 8'h8);
    // each source masked by the other three, then passed alone
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, uibg_pkg::OFF_IRQ_EN, 32'hf ^ (32'h1 << i));
      src(i);
      chk(uart_irq, 1'b0);
      apb(1'b1, uibg_pkg::OFF_IRQ_EN, 32'h1 << i);
      rid(ids[i]);
      chk(uart_irq, 1'b1);
      rx_ready <= 1'b0;
      tx_empty <= 1'b0;
      rd(uibg_pkg::OFF_LINE_ST, {24'h0, 3'h0, i == 2, 4'h0});
      rd(uibg_pkg::OFF_MODEM_ST, {24'h0, 4'ha, 3'h0, i == 3});
      rid(uibg_pkg::ID_NONE);
    end
    rx_timeout <= 1'b1;
    for (int i = 0; i < 4; i++)
      src(i);
    apb(1'b1, uibg_pkg::OFF_IRQ_EN, 32'h0);
    rid(uibg_pkg::ID_NONE);
    chk(uart_irq, 1'b0);
    apb(1'b1, uibg_pkg::OFF_IRQ_EN, 32'hf);
    apb(1'b1, uibg_pkg::OFF_MODEM_CTL, 32'h0);
    rid(uibg_pkg::ID_LINE);
    chk(uart_irq, 1'b0);
    rd(uibg_pkg::OFF_LINE_ST, 32'h10);
    rid(uibg_pkg::ID_TMO);
    rx_timeout <= 1'b0;
    rid(uibg_pkg::ID_RX);
    rx_ready <= 1'b0;
    rid(uibg_pkg::ID_TX);
    tx_empty <= 1'b0;
    rid(uibg_pkg::ID_MODEM);
    // sticky event, masked then unmasked, cleared by writing one
    apb(1'b1, uibg_pkg::OFF_EV_STAT, 32'hf);
    src(2);
    chk(sys_irq, 1'b0);
    apb(1'b1, uibg_pkg::OFF_EV_MASK, 32'h1);
    // sys_irq is registered one edge after the mask: look after it settles
    @(posedge mclk);
    chk(sys_irq, 1'b1);
    apb(1'b1, uibg_pkg::OFF_EV_STAT, 32'h1);
    @(posedge mclk);
    chk(sys_irq, 1'b0);
    // 192 ref edges per 2000 cycles, divided by pre-divider and divisor 2
    apb(1'b1, uibg_pkg::OFF_DIV_HI, 32'h0);
    apb(1'b1, uibg_pkg::OFF_DIV_LO, 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, uibg_pkg::OFF_PRESCALE, {24'h0, pre_sel[k]});
      apb(1'b1, uibg_pkg::OFF_SPEED, {24'h0, spd[k]});
      repeat (300) @(posedge mclk);
      ticks = 0;
      repeat (2000) @(posedge mclk);
      chk((ticks - 1536 / (pre8[k] * 2)) / 3, 0);
    end
    end_of_test();
  end
endmodule
